// file: core/sdc_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by bare name into the setpoint detect block files
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH
// ---------------------------------------------------------------
// byte offsets on the wishbone slave
// ---------------------------------------------------------------
`define SDC_CTRL_OFS    10'h000
`define SDC_STATUS_OFS  10'h004
`define SDC_AUX_OFS     10'h008
`define SDC_CNT_OFS     10'h00c
`define SDC_DAC_BASE    10'h010
`define SDC_SP_BASE     10'h100
`define SDC_SP_CFG_W    2'h0
`define SDC_SP_LIM_W    2'h1
`define SDC_SP_V1_W     2'h2
`define SDC_SP_V2_W     2'h3
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SDC_CFG_CRIT_LSB 0
`define SDC_CFG_UM_LSB   3
`define SDC_CFG_ACT_LSB  5
`define SDC_CFG_TGT_LSB  7
`define SDC_CFG_CHAN_LSB 16
`define SDC_CFG_EN_BIT   31
`define SDC_AUX_OE_BIT   8
// ---------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------
`define SDC_CFG_RST      32'h0000_0000
`define SDC_DAC_RST      16'h0000
`define SDC_AUX_RST      8'h00
`define SDC_TIMER_STOP   16'hffff
`define SDC_CLK_MHZ      50
`define SDC_EVAL_DLY_US  2
`define SDC_EVAL_DLY_CYC (`SDC_EVAL_DLY_US * `SDC_CLK_MHZ)
`endif

// file: core/sdc_pkg.sv
// types shared by the setpoint detect block
// assumes: compiled before any file that imports it
package sdc_pkg;
  typedef enum logic [2:0] {
    CR_INSIDE  = 3'b000,
    CR_OUTSIDE = 3'b001,
    CR_ABOVE   = 3'b010,
    CR_BELOW   = 3'b011,
    CR_EQUAL   = 3'b100,
    CR_HYST    = 3'b101
  } sdc_crit_t;
  typedef enum logic [1:0] {
    UM_NONE = 2'b00,
    UM_TRUE = 2'b01,
    UM_BOTH = 2'b10
  } sdc_umode_t;
  typedef enum logic [1:0] {
    AC_NONE  = 2'b00,
    AC_PORT  = 2'b01,
    AC_DAC   = 2'b10,
    AC_TIMER = 2'b11
  } sdc_action_t;
  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_ARMED = 1'b1
  } sdc_acq_t;
  typedef struct packed {
    logic        valid;
    logic [7:0]  chan;
    logic [15:0] data;
  } sdc_sample_t;
  typedef struct packed {
    logic        load;
    logic        stop;
    logic [1:0]  sel;
    logic [15:0] value;
  } sdc_timer_t;
endpackage : sdc_pkg

// file: core/sdc_top.sv
// setpoint detect and compare block with wishbone register slave
// assumes: samples, scan start and counter word come from logic on CLK
//
// Overview of operation
// [RL1] up to 16 setpoints, each bound to one channel of the scan group
// [RL2] every setpoint holds a 16-bit upper and lower limit
// [RL3] equal and below use upper limit, above uses lower limit
// [RL4] inside is strictly between limits, outside is above upper or below lower
// [RL5] hysteresis: above upper forces value 2, below lower forces value 1
// [RL6] hysteresis: inside the window flag and output hold
// [RL7] update mode none, true only or true and false; true only skips false
// [RL8] true and false mode applies value 1 on true, value 2 on false
// [RL9] each setpoint has a detect flag, 1 when met, 0 when not
// [RL10] detect flags are offered to the acquisition stream
// [RL11] each setpoint is evaluated at most once per scan
// [RL12] comparisons use 16-bit words; counter halves are separate channels
// [RL13] port action writes data byte under mask byte
// [RL14] dac action writes 16-bit value to one of four dacs
// [RL15] action none, port, dac or timer; timer gets stored value
// [RL16] hysteresis sends both values to the same single target
// [RL17] aux port stays undriven until host or setpoint writes it
// [RL18] dacs reset to zero; host may write another initial level
// [RL19] evaluation starts when the acquisition is armed
// [RL20] host uses equality only on counter or digital channels
// [RL21] host loads all setpoint settings before the acquisition
// [RL22] counter word is latched at every start of scan
// [RL23] sample arrives after converter pipeline delay, port updates at once
// [RL24] timer value 65535 stops the timer
// [RL25] unsigned compare in the cycle the sample arrives
// [RL26] flags and hysteresis states clear when the acquisition is armed
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_top (
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire logic                 WB_CYC_I,
  input  wire logic                 WB_STB_I,
  input  wire logic                 WB_WE_I,
  input  wire logic [3:0]           WB_SEL_I,
  input  wire logic [9:0]           WB_ADR_I,
  input  wire logic [31:0]          WB_DAT_I,
  output logic      [31:0]          WB_DAT_O,
  output logic                      WB_ACK_O,
  input  wire sdc_pkg::sdc_sample_t SAMPLE,
  input  wire logic                 SCAN_START,
  input  wire logic [31:0]          COUNTER_IN,
  output logic      [31:0]          COUNTER_LATCHED,
  output logic      [15:0]          DETECT_FLAGS,
  output logic      [7:0]           AUX_PORT_O,
  output logic                      AUX_PORT_OE,
  output logic      [3:0][15:0]     DAC_OUT,
  output sdc_pkg::sdc_timer_t       TIMER_UPD
);
  import sdc_pkg::*;

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction : lane_merge

  // lowest set bit wins; one setpoint per channel keeps hits unique
  function automatic logic [3:0] first_hit(input logic [15:0] v);
    first_hit = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        first_hit = 4'(i);
      end
    end
  endfunction : first_hit

  // single-limit and window criteria, all unsigned
  function automatic logic crit_met(input logic [2:0] crit, input logic [15:0] x,
                                    input logic [15:0] a, input logic [15:0] b);
    case (crit)
      CR_INSIDE:  crit_met = (x < a) && (x > b);
      CR_OUTSIDE: crit_met = (x > a) || (x < b);
      CR_ABOVE:   crit_met = x > b;
      CR_BELOW:   crit_met = x < a;
      CR_EQUAL:   crit_met = x == a;
      default:    crit_met = 1'b0;
    endcase
  endfunction : crit_met

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  logic             ack_reg;
  logic [31:0]      rdat_reg;
  logic [31:0]      rdat_next;
  logic [31:0]      cfg_reg [16];
  logic [31:0]      lim_reg [16];
  logic [15:0]      v1_reg  [16];
  logic [15:0]      v2_reg  [16];
  logic [15:0]      flag_reg;
  logic [15:0]      hyst_reg;
  logic [15:0]      done_reg;
  logic [7:0]       aux_port_reg;
  logic             aux_oe_reg;
  logic [3:0][15:0] dac_reg;
  logic [31:0]      cnt_reg;
  sdc_timer_t       timer_reg;
  sdc_acq_t         acq_reg;

  wire       bus_req  = WB_CYC_I && WB_STB_I && !ack_reg;
  wire       bus_wr   = bus_req && WB_WE_I;
  wire       sp_area  = WB_ADR_I[9:8] == `SDC_SP_BASE >> 8;
  wire [3:0] sp_idx   = WB_ADR_I[7:4];
  wire [1:0] sp_word  = WB_ADR_I[3:2];
  wire       dac_area = WB_ADR_I[9:4] == `SDC_DAC_BASE >> 4;
  wire [1:0] dac_idx  = WB_ADR_I[3:2];
  wire       ctrl_wr  = bus_wr && WB_ADR_I == `SDC_CTRL_OFS && WB_SEL_I[0];
  wire       aux_wr   = bus_wr && WB_ADR_I == `SDC_AUX_OFS;
  wire       arm_wr   = ctrl_wr && WB_DAT_I[0];
  wire       arm_rise = arm_wr && acq_reg == ST_IDLE;
  wire       armed    = acq_reg == ST_ARMED;
  wire [31:0] aux_word = {23'h0, aux_oe_reg, aux_port_reg};
  wire [31:0] aux_wval = lane_merge(aux_word, WB_DAT_I, WB_SEL_I);

  // read selection; unmapped words read as zero but still acknowledge
  wire [31:0] sp_rd = (sp_word == `SDC_SP_CFG_W) ? cfg_reg[sp_idx] :
                      (sp_word == `SDC_SP_LIM_W) ? lim_reg[sp_idx] :
                      (sp_word == `SDC_SP_V1_W)  ? {16'h0, v1_reg[sp_idx]} : {16'h0, v2_reg[sp_idx]};
  assign rdat_next = sp_area                          ? sp_rd :
                     dac_area                         ? {16'h0, dac_reg[dac_idx]} :
                     WB_ADR_I == `SDC_CTRL_OFS        ? {31'h0, armed} :
                     WB_ADR_I == `SDC_STATUS_OFS      ? {15'h0, armed, flag_reg} :
                     WB_ADR_I == `SDC_AUX_OFS         ? aux_word :
                     WB_ADR_I == `SDC_CNT_OFS         ? cnt_reg : 32'h0;

  // one-wait-state answer: ack one cycle after the request, then low
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg  <= bus_req;
      rdat_reg <= rdat_next;
    end
  end
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdat_reg;

  // setpoint settings are loaded by the host before arming [RL21]
  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int i = 0; i < 16; i++) begin
        cfg_reg[i] <= `SDC_CFG_RST;
        lim_reg[i] <= 32'h0;
        v1_reg[i]  <= 16'h0;
        v2_reg[i]  <= 16'h0;
      end
    end else if (bus_wr && sp_area) begin
      case (sp_word)
        `SDC_SP_CFG_W: cfg_reg[sp_idx] <= lane_merge(cfg_reg[sp_idx], WB_DAT_I, WB_SEL_I);
        `SDC_SP_LIM_W: lim_reg[sp_idx] <= lane_merge(lim_reg[sp_idx], WB_DAT_I, WB_SEL_I); // [RL2]
        `SDC_SP_V1_W:  v1_reg[sp_idx]  <= 16'(lane_merge({16'h0, v1_reg[sp_idx]}, WB_DAT_I, WB_SEL_I));
        default:       v2_reg[sp_idx]  <= 16'(lane_merge({16'h0, v2_reg[sp_idx]}, WB_DAT_I, WB_SEL_I));
      endcase
    end
  end

  // acquisition state: writing bit 0 arms, clearing it stops
  always_ff @(posedge CLK) begin
    if (RESET) begin
      acq_reg <= ST_IDLE;
    end else if (ctrl_wr) begin
      acq_reg <= WB_DAT_I[0] ? ST_ARMED : ST_IDLE; // [RL19]
    end
  end

  // ---------------------------------------------------------------
  // per-setpoint comparison
  // ---------------------------------------------------------------
  logic [15:0] hit;
  logic [15:0] new_flag;
  logic [15:0] apply_k;
  logic [15:0] use2_k;
  logic [15:0] is_h;
  logic [15:0] h_hi;
  logic [15:0] h_lo;

  // samples are 16-bit words; a counter's halves arrive as own channels [RL12]
  generate
    for (genvar k = 0; k < 16; k++) begin : g_sp
      wire [15:0] lim_a = lim_reg[k][31:16];
      wire [15:0] lim_b = lim_reg[k][15:0];
      wire [2:0]  crit  = cfg_reg[k][`SDC_CFG_CRIT_LSB +: 3];
      wire [1:0]  umode = cfg_reg[k][`SDC_CFG_UM_LSB +: 2];
      wire        met   = crit_met(crit, SAMPLE.data, lim_a, lim_b); // [RL3] [RL4] [RL25]
      // the done bit keeps a second sample of the same channel from acting [RL11]
      assign hit[k] = SAMPLE.valid && armed && cfg_reg[k][`SDC_CFG_EN_BIT] && (!done_reg[k] || SCAN_START) &&
                      SAMPLE.chan == cfg_reg[k][`SDC_CFG_CHAN_LSB +: 8]; // [RL1] [RL19]
      assign is_h[k] = crit == CR_HYST;
      assign h_hi[k] = SAMPLE.data > lim_a;
      assign h_lo[k] = SAMPLE.data < lim_b;
      // hysteresis holds its state inside the window [RL5] [RL6]
      assign new_flag[k] = is_h[k] ? (h_hi[k] ? 1'b1 : (h_lo[k] ? 1'b0 : hyst_reg[k])) : met;
      assign apply_k[k]  = is_h[k] ? (h_hi[k] || h_lo[k]) :
                           (umode == UM_BOTH) || (umode == UM_TRUE && met); // [RL7] [RL8]
      assign use2_k[k]   = is_h[k] ? h_hi[k] : !met;
    end
  endgenerate

  // flags clear on arming and follow the criterion once per scan [RL9] [RL26]
  always_ff @(posedge CLK) begin
    if (RESET || arm_rise) begin
      flag_reg <= 16'h0;
      hyst_reg <= 16'h0;
      done_reg <= 16'h0;
    end else begin
      flag_reg <= (flag_reg & ~hit) | (new_flag & hit);
      hyst_reg <= (hyst_reg & ~(hit & is_h)) | (new_flag & hit & is_h);
      done_reg <= (done_reg & ~{16{SCAN_START}}) | hit; // a hit in the scan-start cycle wins [RL11]
    end
  end
  assign DETECT_FLAGS = flag_reg; // [RL10]

  // counter word for the stream is caught at each start of scan [RL22]
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cnt_reg <= 32'h0;
    end else if (SCAN_START) begin
      cnt_reg <= COUNTER_IN;
    end
  end
  assign COUNTER_LATCHED = cnt_reg;

  // ---------------------------------------------------------------
  // action on the chosen setpoint
  // ---------------------------------------------------------------
  wire [3:0]  sel      = first_hit(hit);
  wire        any_hit  = |hit;
  wire        upd_go   = any_hit && apply_k[sel];
  // both hysteresis values leave through the one configured target [RL16]
  wire [15:0] upd_val  = use2_k[sel] ? v2_reg[sel] : v1_reg[sel];
  wire [1:0]  upd_act  = cfg_reg[sel][`SDC_CFG_ACT_LSB +: 2];
  wire [1:0]  upd_tgt  = cfg_reg[sel][`SDC_CFG_TGT_LSB +: 2];
  wire        port_go  = upd_go && upd_act == AC_PORT; // [RL15]
  wire        dac_go   = upd_go && upd_act == AC_DAC;
  wire        timer_go = upd_go && upd_act == AC_TIMER;
  wire [7:0]  port_new = (aux_port_reg & ~upd_val[15:8]) | (upd_val[7:0] & upd_val[15:8]);

  // aux port starts undriven; setpoint update wins over a host write [RL17] [RL23]
  always_ff @(posedge CLK) begin
    if (RESET) begin
      aux_port_reg <= `SDC_AUX_RST;
      aux_oe_reg   <= 1'b0;
    end else if (port_go) begin
      aux_port_reg <= port_new; // [RL13]
      aux_oe_reg   <= 1'b1;
    end else if (aux_wr) begin
      aux_port_reg <= aux_wval[7:0];
      aux_oe_reg   <= aux_wval[`SDC_AUX_OE_BIT];
    end
  end
  assign AUX_PORT_O  = aux_port_reg;
  assign AUX_PORT_OE = aux_oe_reg;

  // dacs reset to 0 V; host writes give another start level [RL18] [RL14]
  always_ff @(posedge CLK) begin
    if (RESET) begin
      dac_reg <= {4{`SDC_DAC_RST}};
    end else if (dac_go) begin
      dac_reg[upd_tgt] <= upd_val;
    end else if (bus_wr && dac_area) begin
      dac_reg[dac_idx] <= 16'(lane_merge({16'h0, dac_reg[dac_idx]}, WB_DAT_I, WB_SEL_I));
    end
  end
  assign DAC_OUT = dac_reg;

  // timer load is a one-cycle pulse; all ones means stop [RL24]
  always_ff @(posedge CLK) begin
    if (RESET) begin
      timer_reg <= '0;
    end else begin
      timer_reg.load  <= timer_go;
      timer_reg.stop  <= timer_go && upd_val == `SDC_TIMER_STOP;
      timer_reg.sel   <= timer_go ? upd_tgt : timer_reg.sel;
      timer_reg.value <= timer_go ? upd_val : timer_reg.value;
    end
  end
  assign TIMER_UPD = timer_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  wire        hyst_hold = any_hit && is_h[sel] && !h_hi[sel] && !h_lo[sel];
  wire [1:0]  sel_um    = cfg_reg[sel][`SDC_CFG_UM_LSB +: 2];

  chk_arm_clears_flags: assert property (@(posedge CLK) disable iff (RESET) // [RL26]
    arm_rise |=> flag_reg == 16'h0) else $error("flags not cleared on arm");
  chk_once_per_scan: assert property (@(posedge CLK) disable iff (RESET) // [RL11]
    (!arm_rise && !SCAN_START) ##1 1'b1 |-> ((flag_reg ^ $past(flag_reg)) & $past(done_reg)) == 16'h0)
    else $error("flag changed twice in one scan");
  chk_port_masked: assert property (@(posedge CLK) disable iff (RESET) // [RL13]
    port_go |=> ((AUX_PORT_O ^ $past(aux_port_reg)) & ~$past(upd_val[15:8])) == 8'h0 && AUX_PORT_OE)
    else $error("port bits outside mask changed");
  chk_dac_written: assert property (@(posedge CLK) disable iff (RESET) // [RL14]
    dac_go |=> DAC_OUT[$past(upd_tgt)] == $past(upd_val)) else $error("dac not updated");
  chk_timer_stop: assert property (@(posedge CLK) disable iff (RESET) // [RL24]
    timer_go && upd_val == 16'hffff |=> TIMER_UPD.stop && TIMER_UPD.load) else $error("timer not stopped");
  chk_hyst_hold: assert property (@(posedge CLK) disable iff (RESET) // [RL6]
    hyst_hold |-> !upd_go ##1 $stable(flag_reg)) else $error("hysteresis changed inside window");
  chk_dac_reset: assert property (@(posedge CLK) // [RL18]
    RESET |=> DAC_OUT == 64'h0) else $error("dac not zero after reset");
  chk_true_only: assert property (@(posedge CLK) disable iff (RESET) // [RL7]
    (any_hit && !is_h[sel] && sel_um == UM_TRUE) |-> upd_go == new_flag[sel]) else $error("true-only misfire");
  chk_idle_no_hit: assert property (@(posedge CLK) disable iff (RESET) // [RL19]
    !armed |-> hit == 16'h0 ##1 !TIMER_UPD.load) else $error("evaluation while idle");

  // bus answer: exactly one wait state and a one-cycle acknowledge
  chk_ack_follows_req: assert property (@(posedge CLK) disable iff (RESET)
    bus_req |=> WB_ACK_O)
    else $error("request not acknowledged");
  chk_ack_one_cycle: assert property (@(posedge CLK) disable iff (RESET)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge held too long");

  // a flag moves only where its setpoint was taken in the cycle before
  chk_flag_needs_hit: assert property (@(posedge CLK) disable iff (RESET) // [RL9]
    !arm_rise |=> ((flag_reg ^ $past(flag_reg)) & ~$past(hit)) == 16'h0)
    else $error("flag moved without a sample");

  // hysteresis forces the flag by the side of the window that was left
  chk_hyst_high: assert property (@(posedge CLK) disable iff (RESET) // [RL5]
    any_hit && is_h[sel] && h_hi[sel] |=> DETECT_FLAGS[$past(sel)])
    else $error("hysteresis high not forced");
  chk_hyst_low: assert property (@(posedge CLK) disable iff (RESET) // [RL5]
    any_hit && is_h[sel] && h_lo[sel] && !h_hi[sel] |=> !DETECT_FLAGS[$past(sel)])
    else $error("hysteresis low not forced");

  // true and false mode: the dac gets value 1 on true and value 2 on false
  chk_both_true: assert property (@(posedge CLK) disable iff (RESET) // [RL8]
    dac_go && !is_h[sel] && sel_um == UM_BOTH && new_flag[sel] |=> DAC_OUT[$past(upd_tgt)] == $past(v1_reg[sel]))
    else $error("true value not applied");
  chk_both_false: assert property (@(posedge CLK) disable iff (RESET) // [RL8]
    dac_go && !is_h[sel] && sel_um == UM_BOTH && !new_flag[sel] |=> DAC_OUT[$past(upd_tgt)] == $past(v2_reg[sel]))
    else $error("false value not applied");

  // counter word at start of scan; port left undriven by reset
  chk_counter_latch: assert property (@(posedge CLK) disable iff (RESET) // [RL22]
    SCAN_START |=> COUNTER_LATCHED == $past(COUNTER_IN))
    else $error("counter word not latched");
  chk_oe_after_reset: assert property (@(posedge CLK) // [RL17]
    RESET |=> !AUX_PORT_OE)
    else $error("aux port driven after reset");
endmodule : sdc_top

// file: verification/sdc_scan_model.sv
// acquisition scan sequencer model: scan start pulses, 16-bit samples and a counter word
// assumes: shares the block clock; the bench calls start_scan and send hierarchically
`timescale 1ns/1ps
module sdc_scan_model (
  input  wire logic            clk,
  output sdc_pkg::sdc_sample_t sample,
  output logic                 scan_start,
  output logic [31:0]          counter,
  output logic [31:0]          snap
);
  import sdc_pkg::*;
  // quiet at time zero
  initial begin
    sample = '0;
    scan_start = 1'b0;
    counter = 32'h0000_0000;
    snap = 32'h0000_0000;
  end
  // counter runs faster than the scan rate; snap keeps the word seen at scan start
  always @(posedge clk) begin
    counter <= counter + 32'h0000_0003;
    if (scan_start) begin
      snap <= counter;
    end
  end
  // one-cycle scan start pulse
  task start_scan();
    @(posedge clk);
    scan_start <= 1'b1;
    @(posedge clk);
    scan_start <= 1'b0;
  endtask : start_scan
  // one 16-bit word, already past the converter pipeline
  // after the strobe the bus shows the inverse so stale data never looks valid
  task send(input logic [7:0] ch, input logic [15:0] d);
    @(posedge clk);
    sample <= '{valid: 1'b1, chan: ch, data: d};
    @(posedge clk);
    sample <= '{valid: 1'b0, chan: ~ch, data: ~d};
  endtask : send
endmodule : sdc_scan_model

// file: verification/sdc_top_bench.sv
// self-checking bench for the setpoint detect block: wishbone host plus scan sequencer model
// assumes: design files and sdc_scan_model compiled first
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_top_bench;
  import sdc_pkg::*;
  localparam int NS = 6;
  localparam int NT = 19;
  logic clk, reset, cyc, stb, we, ack, oe, scan_start;
  logic [3:0] sel;
  logic [9:0] adr;
  logic [31:0] wdat, dat_o, q, latched, counter, snap;
  logic [15:0] flags, e_flags;
  logic [7:0] port, e_port;
  logic [3:0][15:0] dac, e_dac;
  logic e_oe, e_load, e_stop;
  logic [1:0] e_sel;
  logic [15:0] e_val;
  sdc_sample_t sample;
  sdc_timer_t timer;
  int num_errors, checked;
  // setpoint table: criteria, update mode, action, target, limits, values
  sdc_crit_t   crit [NS] = '{CR_INSIDE, CR_EQUAL, CR_HYST, CR_ABOVE, CR_BELOW, CR_OUTSIDE};
  sdc_umode_t  um   [NS] = '{UM_BOTH, UM_TRUE, UM_NONE, UM_BOTH, UM_BOTH, UM_TRUE};
  sdc_action_t act  [NS] = '{AC_DAC, AC_PORT, AC_TIMER, AC_DAC, AC_DAC, AC_PORT};
  logic [1:0]  tgt  [NS] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h1, 2'h0};
  logic [15:0] lim_a[NS] = '{16'h1000, 16'h00c3, 16'h8000, 16'h0000, 16'h0200, 16'h3000};
  logic [15:0] lim_b[NS] = '{16'h0800, 16'hffff, 16'h4000, 16'h0100, 16'hffff, 16'h2000};
  logic [15:0] val1 [NS] = '{16'haaaa, 16'h0fa3, 16'h0011, 16'h1357, 16'h2468, 16'hf0c5};
  logic [15:0] val2 [NS] = '{16'h5555, 16'h0f11, 16'hffff, 16'h9bdf, 16'h0acf, 16'hff00};
  // boundary samples: limits themselves, one past them, hysteresis holds
  int          st_sp[NT] = '{0, 0, 0, 0, 1, 1, 2, 2, 2, 2, 2, 2, 3, 3, 4, 4, 5, 5, 5};
  logic [15:0] st_x [NT] = '{16'h0fff, 16'h1000, 16'h0800, 16'h0801, 16'h00c3, 16'h00c4,
                             16'h8001, 16'h6000, 16'h8000, 16'h3fff, 16'h4000, 16'h8001,
                             16'h0101, 16'h0100, 16'h01ff, 16'h0200, 16'h3001, 16'h2000, 16'h1fff};
  sdc_top sdc_top_i (.CLK(clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .SAMPLE(sample), .SCAN_START(scan_start), .COUNTER_IN(counter), .COUNTER_LATCHED(latched),
    .DETECT_FLAGS(flags), .AUX_PORT_O(port), .AUX_PORT_OE(oe), .DAC_OUT(dac), .TIMER_UPD(timer));
  sdc_scan_model sdc_scan_model_i (.clk(clk), .sample(sample), .scan_start(scan_start),
    .counter(counter), .snap(snap));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // classic single cycle; waits for ack for at most 20 clock cycles, bounded by a count
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk(32'(n < 20), 32'h1, "bus answer");
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb
  // reference behaviour for one accepted sample of setpoint k
  task automatic model(input int k, input logic [15:0] x);
    logic r, upd;
    logic [15:0] v;
    r = e_flags[k];
    upd = 1'b1;
    e_load = 1'b0;
    e_stop = 1'b0;
    case (crit[k])
      CR_INSIDE:  r = (x < lim_a[k]) && (x > lim_b[k]);
      CR_OUTSIDE: r = (x > lim_a[k]) || (x < lim_b[k]);
      CR_ABOVE:   r = x > lim_b[k];
      CR_BELOW:   r = x < lim_a[k];
      CR_EQUAL:   r = x == lim_a[k];
      default:    upd = (x > lim_a[k]) || (x < lim_b[k]);
    endcase
    if (crit[k] == CR_HYST && upd) begin
      r = x > lim_a[k];
    end
    e_flags[k] = r;
    v = (crit[k] == CR_HYST) ? (r ? val2[k] : val1[k]) : (r ? val1[k] : val2[k]);
    if (crit[k] != CR_HYST) begin
      upd = (um[k] == UM_BOTH) || (um[k] == UM_TRUE && r);
    end
    if (upd && act[k] == AC_PORT) begin
      e_port = (e_port & ~v[15:8]) | (v[7:0] & v[15:8]);
      e_oe = 1'b1;
    end
    if (upd && act[k] == AC_DAC) begin
      e_dac[tgt[k]] = v;
    end
    if (upd && act[k] == AC_TIMER) begin
      e_load = 1'b1;
      e_stop = v == 16'hffff;
      e_sel = tgt[k];
      e_val = v;
    end
  endtask : model
  // compare flags, port, dacs and timer against the reference, in the cycle after the taking edge
  task automatic check_all();
    @(negedge clk);
    chk(32'(flags), 32'(e_flags), "flags");
    chk({oe, port}, {e_oe, e_port}, "port");
    for (int i = 0; i < 4; i++) begin
      chk(32'(dac[i]), 32'(e_dac[i]), "dac");
    end
    chk(32'(timer), 32'({e_load, e_stop, e_sel, e_val}), "timer");
  endtask : check_all
  task automatic stop_test();
    $display("checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial begin
    {reset, cyc, stb, we, sel, adr, wdat} = {1'b1, 3'h0, 4'hf, 10'h000, 32'h0000_0000};
    {e_flags, e_port, e_oe, e_dac, e_load, e_stop, e_sel, e_val} = '0;
    num_errors = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check_all();
    wb(1'b0, 10'h3fc, 32'h0000_0000);
    chk(q, 32'h0000_0000, "unmapped read");
    wb(1'b1, `SDC_AUX_OFS, 32'h0000_015a);
    wb(1'b1, `SDC_DAC_BASE + 10'h00c, 32'h0000_1234);
    {e_oe, e_port} = 9'h15a;
    e_dac[3] = 16'h1234;
    check_all();
    for (int k = 0; k < NS; k++) begin
      wb(1'b1, `SDC_SP_BASE + 10'(16 * k), {1'b1, 7'h00, 8'(8'h10 + k), 7'h00, tgt[k], act[k], um[k], crit[k]});
      wb(1'b1, `SDC_SP_BASE + 10'(16 * k + 4), {lim_a[k], lim_b[k]});
      wb(1'b1, `SDC_SP_BASE + 10'(16 * k + 8), {16'h0000, val1[k]});
      wb(1'b1, `SDC_SP_BASE + 10'(16 * k + 12), {16'h0000, val2[k]});
    end
    sdc_scan_model_i.send(8'h13, 16'h0101);
    check_all();
    wb(1'b1, `SDC_CTRL_OFS, 32'h0000_0001);
    for (int i = 0; i < NT; i++) begin
      sdc_scan_model_i.start_scan();
      sdc_scan_model_i.send(8'(8'h10 + st_sp[i]), st_x[i]);
      model(st_sp[i], st_x[i]);
      check_all();
    end
    sdc_scan_model_i.start_scan();
    @(negedge clk);
    chk(latched, snap, "counter latch");
    sdc_scan_model_i.send(8'h10, 16'h0900);
    model(0, 16'h0900);
    sdc_scan_model_i.send(8'h10, 16'h1000);
    check_all();
    wb(1'b0, `SDC_STATUS_OFS, 32'h0000_0000);
    chk(q[16:0], {1'b1, e_flags}, "status");
    wb(1'b1, `SDC_CTRL_OFS, 32'h0000_0000);
    um[3] = UM_NONE;
    act[4] = AC_NONE;
    for (int k = 3; k < 5; k++) begin
      q = {1'b1, 7'h00, 8'(8'h10 + k), 7'h00, tgt[k], act[k], um[k], crit[k]};
      wb(1'b1, `SDC_SP_BASE + 10'(16 * k), q);
    end
    wb(1'b1, `SDC_CTRL_OFS, 32'h0000_0001);
    e_flags = '0;
    sdc_scan_model_i.start_scan();
    sdc_scan_model_i.send(8'h12, 16'h6000);
    model(2, 16'h6000);
    sdc_scan_model_i.send(8'h13, 16'h0101);
    model(3, 16'h0101);
    sdc_scan_model_i.send(8'h14, 16'h01ff);
    model(4, 16'h01ff);
    check_all();
    stop_test();
  end
endmodule : sdc_top_bench
